// ---- src/dac_cal_math.sv ----
package dac_cal_pkg;
    localparam int          RES_DEF       = 14;
    localparam int          NCH_DEF       = 16;
    // Reset values for 14-bit and 12-bit builds
    localparam logic [13:0] GAIN_DEF_14   = 14'h3FFE;
    localparam logic [13:0] GAIN_DEF_12   = 14'h0FFE;
    localparam logic [13:0] OFFS_DEF_14   = 14'h2000;
    localparam logic [13:0] OFFS_DEF_12   = 14'h0800;
    localparam logic [13:0] CODE_DEF      = 14'h0000;
    // Register select encodings
    localparam logic [1:0]  SEL_INPUT     = 2'h3;
    localparam logic [1:0]  SEL_OFFSET    = 2'h2;
    localparam logic [1:0]  SEL_GAIN      = 2'h1;
    // Longest allowed reset sequence and its cycle count at 10 MHz
    localparam int          RESET_MAX_US  = 270;
    localparam int          CLK_MHZ       = 10;
    localparam int          RESET_MAX_CYC = RESET_MAX_US * CLK_MHZ;
    typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_RESET} state_t;
endpackage : dac_cal_pkg

`timescale 1ns/10ps
`default_nettype none

module dac_cal_math #(
    parameter int RES = 14
) (
    // Operands
    input  wire logic [RES-1:0] code_i,
    input  wire logic [RES-1:0] gain_i,
    input  wire logic [RES-1:0] offs_i,
    // Clamped converter code
    output logic      [RES-1:0] result_o
);
    logic        [RES:0]     gain2;
    logic        [2*RES+1:0] prod;
    logic signed [RES+2:0]   sum;

    always_comb
    begin
        gain2 = {1'b0, gain_i} + (RES+1)'(2);
        prod  = {{(RES+1){1'b0}}, gain2} * {{(RES+2){1'b0}}, code_i};
        sum   = signed'({2'b00, prod[2*RES:RES]}) + signed'({3'b000, offs_i})
              - signed'((RES+3)'(1) << (RES-1));
        if (sum < 0)
            result_o = '0;
        else if (sum > signed'({3'b000, {RES{1'b1}}}))
            result_o = {RES{1'b1}};
        else
            result_o = sum[RES-1:0];
    end
endmodule : dac_cal_math

`default_nettype wire

// ---- src/dac_channel_gain_offset_calc.sv ----
`timescale 1ns/10ps
`default_nettype none

module dac_channel_gain_offset_calc #(
    parameter int NCH  = dac_cal_pkg::NCH_DEF,
    parameter int RES  = dac_cal_pkg::RES_DEF,
    parameter int CH_W = $clog2(NCH)
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Channel write port from the serial front end
    input  wire logic                 wr_en_i,
    input  wire logic [CH_W-1:0]      wr_chan_i,
    input  wire logic                 reg_select_hi_i,
    input  wire logic                 reg_select_lo_i,
    input  wire logic [RES-1:0]       wr_data_i,
    // Pins
    input  wire logic                 load_outputs_strobe_n_i,
    input  wire logic                 reset_seq_n_i,
    // Results
    output logic      [NCH*RES-1:0]   converter_code_o,
    output logic                      busy_n_o
);
    localparam logic [RES-1:0] GAIN_RST = (RES == 12) ? dac_cal_pkg::GAIN_DEF_12[RES-1:0]
                                                      : dac_cal_pkg::GAIN_DEF_14[RES-1:0];
    localparam logic [RES-1:0] OFFS_RST = (RES == 12) ? dac_cal_pkg::OFFS_DEF_12[RES-1:0]
                                                      : dac_cal_pkg::OFFS_DEF_14[RES-1:0];
    localparam logic [RES-1:0] CODE_RST = dac_cal_pkg::CODE_DEF[RES-1:0];

    dac_cal_pkg::state_t state_q;
    logic [RES-1:0]      input_q [NCH];
    logic [RES-1:0]      gain_q  [NCH];
    logic [RES-1:0]      offs_q  [NCH];
    logic [RES-1:0]      stage_q [NCH];
    logic [RES-1:0]      conv_q  [NCH];
    logic [CH_W-1:0]     calc_ch_q;
    logic [CH_W-1:0]     rst_idx_q;
    logic                pend_q;
    logic                busy_n_q;
    logic [2:0]          ld_sync_q;
    logic [2:0]          rs_sync_q;
    logic [RES-1:0]      calc_res;
    logic                ld_fall;
    logic                rs_fall;
    logic                wr_take;
    logic                load_now;
    logic [1:0]          sel;

    assign sel      = {reg_select_hi_i, reg_select_lo_i};
    assign ld_fall  = ld_sync_q[2] & ~ld_sync_q[1];
    assign rs_fall  = rs_sync_q[2] & ~rs_sync_q[1];
    assign wr_take  = wr_en_i && (state_q == dac_cal_pkg::ST_IDLE) && !rs_fall
                      && (sel != 2'h0);
    assign load_now = (state_q == dac_cal_pkg::ST_IDLE) && !rs_fall && (ld_fall || pend_q);

    // Pin synchronisers; bit 0 feeds only bit 1
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ld_sync_q <= 3'h7;
            rs_sync_q <= 3'h7;
        end
        else
        begin
            ld_sync_q <= {ld_sync_q[1:0], load_outputs_strobe_n_i};
            rs_sync_q <= {rs_sync_q[1:0], reset_seq_n_i};
        end
    end

    dac_cal_math #(
        .RES      (RES)
    ) u_math (
        .code_i   (input_q[calc_ch_q]),
        .gain_i   (gain_q[calc_ch_q]),
        .offs_i   (offs_q[calc_ch_q]),
        .result_o (calc_res)
    );

    // Sequencer
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q   <= dac_cal_pkg::ST_IDLE;
            calc_ch_q <= '0;
            rst_idx_q <= '0;
            busy_n_q  <= 1'b1;
        end
        else if (rs_fall && state_q != dac_cal_pkg::ST_RESET)
        begin
            state_q   <= dac_cal_pkg::ST_RESET;
            rst_idx_q <= '0;
            busy_n_q  <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                dac_cal_pkg::ST_IDLE:
                begin
                    if (wr_take)
                    begin
                        state_q   <= dac_cal_pkg::ST_CALC;
                        calc_ch_q <= wr_chan_i;
                        busy_n_q  <= 1'b0;
                    end
                end
                dac_cal_pkg::ST_CALC:
                begin
                    state_q  <= dac_cal_pkg::ST_IDLE;
                    busy_n_q <= 1'b1;
                end
                dac_cal_pkg::ST_RESET:
                begin
                    rst_idx_q <= rst_idx_q + CH_W'(1);
                    if (rst_idx_q == CH_W'(NCH - 1))
                    begin
                        state_q  <= dac_cal_pkg::ST_IDLE;
                        busy_n_q <= 1'b1;
                    end
                end
                default:
                begin
                    state_q  <= dac_cal_pkg::ST_IDLE;
                    busy_n_q <= 1'b1;
                end
            endcase
        end
    end

    // Load remembered while busy, dropped during reset sequence
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            pend_q <= 1'b0;
        else if (rs_fall || state_q == dac_cal_pkg::ST_RESET)
            pend_q <= 1'b0;
        else if (state_q == dac_cal_pkg::ST_CALC && ld_fall)
            pend_q <= 1'b1;
        else if (load_now)
            pend_q <= 1'b0;
    end

    // Per-channel storage
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_chan
            logic clr;
            logic hit;
            assign clr = (state_q == dac_cal_pkg::ST_RESET) && (rst_idx_q == CH_W'(g));
            assign hit = wr_take && (wr_chan_i == CH_W'(g));

            always_ff @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    input_q[g] <= CODE_RST;
                    gain_q[g]  <= GAIN_RST;
                    offs_q[g]  <= OFFS_RST;
                end
                else if (clr)
                begin
                    input_q[g] <= CODE_RST;
                    gain_q[g]  <= GAIN_RST;
                    offs_q[g]  <= OFFS_RST;
                end
                else if (hit)
                begin
                    if (sel == dac_cal_pkg::SEL_INPUT)
                        input_q[g] <= wr_data_i;
                    if (sel == dac_cal_pkg::SEL_OFFSET)
                        offs_q[g] <= wr_data_i;
                    if (sel == dac_cal_pkg::SEL_GAIN)
                        gain_q[g] <= {wr_data_i[RES-1:1], 1'b0};
                end
            end

            always_ff @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                    stage_q[g] <= CODE_RST;
                else if (clr)
                    stage_q[g] <= CODE_RST;
                else if (state_q == dac_cal_pkg::ST_CALC && calc_ch_q == CH_W'(g))
                    stage_q[g] <= calc_res;
            end

            always_ff @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                    conv_q[g] <= CODE_RST;
                else if (clr)
                    conv_q[g] <= CODE_RST;
                else if (load_now)
                    conv_q[g] <= stage_q[g];
            end

            assign converter_code_o[g*RES +: RES] = conv_q[g];
        end
    endgenerate

    assign busy_n_o = busy_n_q;

endmodule : dac_channel_gain_offset_calc

`default_nettype wire

// ---- verif/dac_cal_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module dac_cal_props #(parameter int NCH = 16, parameter int RES = 14, parameter int CH_W = 4) (
    input wire logic clk_i, rst_i, wr_en_i, reg_select_hi_i, reg_select_lo_i,
    input wire logic [CH_W-1:0] wr_chan_i,
    input wire logic [RES-1:0] wr_data_i,
    input wire logic load_outputs_strobe_n_i, reset_seq_n_i, busy_n_o,
    input wire logic [NCH*RES-1:0] converter_code_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence quiet_s;
        reset_seq_n_i && $past(reset_seq_n_i) && $past(reset_seq_n_i, 2) && $past(reset_seq_n_i, 3);
    endsequence
    sequence take_s;
        wr_en_i && busy_n_o && (reg_select_hi_i || reg_select_lo_i) ##0 quiet_s;
    endsequence
    sequence rseq_s;
        $fell(reset_seq_n_i) && busy_n_o ##3 (!busy_n_o)[*8] ##(NCH-7) busy_n_o;
    endsequence
    write_busy_a: assert property (take_s |=> !busy_n_o ##1 busy_n_o)
        else $error("write busy pulse wrong");
    write_refuse_a: assert property (take_s ##1 wr_en_i ##1 !wr_en_i |=> busy_n_o)
        else $error("write while busy was taken");
    sel_none_a: assert property (wr_en_i && busy_n_o && !reg_select_hi_i && !reg_select_lo_i
        ##0 quiet_s |=> busy_n_o) else $error("select none was taken");
    busy_bound_a: assert property ($fell(busy_n_o) |-> ##[1:16] busy_n_o)
        else $error("busy held too long");
    rseq_len_a: assert property ($fell(reset_seq_n_i) && busy_n_o
        |-> ##3 (!busy_n_o)[*8] ##(NCH-7) busy_n_o) else $error("reset sequence length wrong");
    rseq_clear_a: assert property (rseq_s |-> converter_code_o == '0)
        else $error("reset sequence left codes");
    rst_out_a: assert property ($fell(rst_i) |-> converter_code_o == '0 && busy_n_o)
        else $error("reset values wrong");
    out_hold_a: assert property (!$stable(converter_code_o) |-> !busy_n_o || !$past(busy_n_o)
        || !($past(load_outputs_strobe_n_i, 3) && $past(load_outputs_strobe_n_i, 4)
        && $past(load_outputs_strobe_n_i, 5))) else $error("codes changed without load");
endmodule : dac_cal_props
`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_model #(parameter int RES = 14, parameter int CH_W = 4) (
    input wire logic clk_i, busy_n_i,
    output logic wr_en_o, hi_o, lo_o,
    output logic [CH_W-1:0] chan_o,
    output logic [RES-1:0] data_o
);
    initial {wr_en_o, hi_o, lo_o, chan_o, data_o} = '0;
    // Idle bus shows changing junk; refuse pushes inverted data for one more cycle while busy
    task automatic write(input logic [1:0] sel, input logic [CH_W-1:0] ch,
                         input logic [RES-1:0] d, input bit refuse);
        @(negedge clk_i);
        while (!busy_n_i) @(negedge clk_i);
        {wr_en_o, hi_o, lo_o, chan_o, data_o} <= {1'b1, sel, ch, d};
        @(negedge clk_i);
        if (refuse)
        begin
            data_o <= ~d;
            @(negedge clk_i);
        end
        {wr_en_o, hi_o, lo_o, chan_o, data_o} <= {1'b0, 2'($urandom), CH_W'($urandom), RES'($urandom)};
    endtask : write
endmodule : host_model
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int NCH = 16;
    localparam int RES = 14;
    localparam int R12 = 12;
    localparam int CH_W = 4;
    localparam int MASK = (1 << RES) - 1;
    logic clk_i = 0, rst_i = 1, load_n = 1, rseq_n = 1, wr_en, hi, lo, busy_n, busy12_n;
    logic [CH_W-1:0] chan;
    logic [RES-1:0] data;
    logic [NCH*RES-1:0] code;
    logic [NCH*R12-1:0] code12;
    int err_total = 0, checked = 0;
    // Index 0 models the 14-bit build, index 1 the 12-bit build
    int xin[2][NCH], gn[2][NCH], off[2][NCH], outm[2][NCH];
    dac_channel_gain_offset_calc #(.NCH(NCH), .RES(RES), .CH_W(CH_W)) dut (.clk_i(clk_i),
        .rst_i(rst_i), .wr_en_i(wr_en), .wr_chan_i(chan), .reg_select_hi_i(hi),
        .reg_select_lo_i(lo), .wr_data_i(data), .load_outputs_strobe_n_i(load_n),
        .reset_seq_n_i(rseq_n), .converter_code_o(code), .busy_n_o(busy_n));
    dac_channel_gain_offset_calc #(.NCH(NCH), .RES(R12), .CH_W(CH_W)) dut12 (.clk_i(clk_i),
        .rst_i(rst_i), .wr_en_i(wr_en), .wr_chan_i(chan), .reg_select_hi_i(hi),
        .reg_select_lo_i(lo), .wr_data_i(data[R12-1:0]), .load_outputs_strobe_n_i(load_n),
        .reset_seq_n_i(rseq_n), .converter_code_o(code12), .busy_n_o(busy12_n));
    host_model #(.RES(RES), .CH_W(CH_W)) host (.clk_i(clk_i), .busy_n_i(busy_n),
        .wr_en_o(wr_en), .hi_o(hi), .lo_o(lo), .chan_o(chan), .data_o(data));
    initial forever #50 clk_i = ~clk_i;
    function automatic int calc(int k, int c);
        int r = k ? R12 : RES;
        int v = (((gn[k][c] + 2) * xin[k][c]) >>> r) + off[k][c] - (1 << (r - 1));
        int m = (1 << r) - 1;
        return v < 0 ? 0 : (v > m ? m : v);
    endfunction : calc
    task automatic check(input logic [RES-1:0] got, input logic [RES-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic check_all();
        for (int c = 0; c < NCH; c++)
        begin
            check(code[c*RES +: RES], RES'(outm[0][c]));
            check(RES'(code12[c*R12 +: R12]), RES'(outm[1][c]));
        end
        check(RES'({busy_n, busy12_n}), RES'(3));
    endtask : check_all
    task automatic defaults();
        for (int c = 0; c < NCH; c++)
        begin
            for (int k = 0; k < 2; k++)
            begin
                xin[k][c] = 0;
                outm[k][c] = 0;
            end
            gn[0][c] = 'h3FFE;
            gn[1][c] = 'hFFE;
            off[0][c] = 'h2000;
            off[1][c] = 'h800;
        end
    endtask : defaults
    task automatic wr(input int sel, input int c, input int d, input bit refuse = 0);
        host.write(2'(sel), CH_W'(c), RES'(d), refuse);
        for (int k = 0; k < 2; k++)
            if (sel == 3) xin[k][c] = d & (k ? 'hFFF : MASK);
            else if (sel == 2) off[k][c] = d & (k ? 'hFFF : MASK);
            else if (sel == 1) gn[k][c] = d & (k ? 'hFFE : MASK - 1);
    endtask : wr
    task automatic expect_all();
        for (int c = 0; c < NCH; c++)
            for (int k = 0; k < 2; k++)
                outm[k][c] = calc(k, c);
    endtask : expect_all
    task automatic load();
        @(negedge clk_i) load_n <= 0;
        repeat (2) @(negedge clk_i);
        load_n <= 1;
        repeat (4) @(negedge clk_i);
        expect_all();
    endtask : load
    task automatic rounds(input int n);
        repeat (n)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                wr(3, c, $urandom & MASK);
                wr(2, c, $urandom & MASK);
                wr(1, c, $urandom & MASK, c == 3);
                wr(0, c, $urandom & MASK);
            end
            load();
            check_all();
        end
    endtask : rounds
    task automatic conclude();
        $display("checked %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    initial
    begin
        #4000000;
        err_total++;
        conclude();
    end
    initial
    begin
        void'($urandom(32'h15B2427C));
        defaults();
        repeat (12) @(negedge clk_i);
        rst_i <= 0;
        wr(3, 7, MASK);
        load();
        check_all();
        rounds(3);
        @(negedge clk_i) rst_i <= 1;
        @(negedge clk_i) rst_i <= 0;
        defaults();
        check_all();
        rounds(1);
        @(negedge clk_i) load_n <= 0;
        wr(3, 5, 'h1234);
        check(RES'({busy_n, busy12_n}), RES'(0));
        load_n <= 1;
        repeat (4) @(negedge clk_i);
        expect_all();
        check_all();
        @(negedge clk_i) rseq_n <= 0;
        repeat (6) @(negedge clk_i);
        check(RES'({busy_n, busy12_n}), RES'(0));
        repeat (NCH) @(negedge clk_i);
        rseq_n <= 1;
        defaults();
        check_all();
        wr(3, 2, MASK);
        load();
        check_all();
        conclude();
    end
endmodule : tb
bind dac_channel_gain_offset_calc dac_cal_props #(.NCH(NCH), .RES(RES), .CH_W(CH_W)) props (
    .clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i), .reg_select_hi_i(reg_select_hi_i),
    .reg_select_lo_i(reg_select_lo_i), .wr_chan_i(wr_chan_i), .wr_data_i(wr_data_i),
    .load_outputs_strobe_n_i(load_outputs_strobe_n_i), .reset_seq_n_i(reset_seq_n_i),
    .busy_n_o(busy_n_o), .converter_code_o(converter_code_o));
`default_nettype wire
